/* File: nva_pkg.sv */
package nva_pkg;

  // ----------------------------------------------------------------
  // I/O register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_REG_OFS = 6'h1e;
  localparam logic [5:0] DATA_REG_OFS = 6'h1d;
  localparam logic [5:0] CTRL_REG_OFS = 6'h1c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int RD_STROBE_BIT = 0;
  localparam int WR_STROBE_BIT = 1;
  localparam int WR_ARM_BIT    = 2;

  // ----------------------------------------------------------------
  // Array geometry and reset values
  // ----------------------------------------------------------------
  localparam int         ARRAY_DEPTH = 128;
  localparam int         ADDR_W      = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] REG_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ARM_CYCLES     = 4;
  localparam int WR_STALL_CYC   = 2;
  localparam int RD_STALL_CYC   = 4;
  localparam int WR_TIME_US     = 2500;
  localparam int WR_TIME_CYC    = WR_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_FRACTION = 2;

endpackage : nva_pkg

/* File: nva_access_ctrl.sv */
`timescale 1ns/100ps

module nva_access_ctrl #(
  parameter int WR_CYCLES = nva_pkg::WR_TIME_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // I/O bus from the core
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Core stall
  output logic            cpu_stall
);

  localparam int CW = $clog2(WR_CYCLES + 1);
  localparam logic [CW-1:0] WR_LAST = CW'(WR_CYCLES - 1);
  localparam logic [CW-1:0] ERASE_END = CW'(WR_CYCLES / nva_pkg::ERASE_FRACTION);

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} nva_wstate_t;

  typedef struct packed {
    logic [nva_pkg::ADDR_W-1:0] addr;
    logic [7:0]                 data;
    logic                       arm;
    logic [2:0]                 arm_cnt;
    logic                       wr_busy;
    nva_wstate_t                wst;
    logic [CW-1:0]              wcnt;
    logic [2:0]                 stall_cnt;
    logic [7:0]                 rdata;
    logic                       stall;
  } nva_state_t;

  nva_state_t st_ff;
  nva_state_t nxt_st;

  logic [7:0] mem_ff [nva_pkg::ARRAY_DEPTH];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic wr_go;
  logic rd_go;
  assign wr_ctrl = io_wr && io_addr == nva_pkg::CTRL_REG_OFS;
  assign wr_addr = io_wr && io_addr == nva_pkg::ADDR_REG_OFS;
  assign wr_data = io_wr && io_addr == nva_pkg::DATA_REG_OFS;
  // Write strobe only counts if armed and no write is running
  assign wr_go = wr_ctrl && io_wdata[nva_pkg::WR_STROBE_BIT] && st_ff.arm
                 && !st_ff.wr_busy;
  assign rd_go = wr_ctrl && io_wdata[nva_pkg::RD_STROBE_BIT]
                 && !st_ff.wr_busy;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (wr_addr) begin
      nxt_st.addr = io_wdata[nva_pkg::ADDR_W-1:0];
    end
    if (wr_data) begin
      nxt_st.data = io_wdata;
    end
    // Arm timeout
    if (st_ff.arm) begin
      nxt_st.arm_cnt = st_ff.arm_cnt + 3'h1;
      if (st_ff.arm_cnt == 3'(nva_pkg::ARM_CYCLES - 1)) begin
        nxt_st.arm = 1'b0;
      end
    end
    if (wr_ctrl && io_wdata[nva_pkg::WR_ARM_BIT]
        && !io_wdata[nva_pkg::WR_STROBE_BIT]) begin
      nxt_st.arm     = 1'b1;
      nxt_st.arm_cnt = 3'h0;
    end
    if (wr_go) begin
      nxt_st.arm     = 1'b0;
      nxt_st.wr_busy = 1'b1;
      nxt_st.wst     = ST_ERASE;
      nxt_st.wcnt    = '0;
      nxt_st.stall_cnt = 3'(nva_pkg::WR_STALL_CYC);
    end
    unique case (st_ff.wst)
      ST_IDLE: begin
      end
      ST_ERASE: begin
        nxt_st.wcnt = st_ff.wcnt + CW'(1);
        if (st_ff.wcnt == ERASE_END) begin
          nxt_st.wst = ST_PROG;
        end
      end
      ST_PROG: begin
        nxt_st.wcnt = st_ff.wcnt + CW'(1);
        if (st_ff.wcnt >= WR_LAST) begin
          nxt_st.wst     = ST_IDLE;
          nxt_st.wr_busy = 1'b0;
        end
      end
    endcase
    // Abort leaves the location erased to ERASED_BYTE (whatever phase reached)
    if ((wr_addr || wr_data) && st_ff.wr_busy) begin
      nxt_st.wst     = ST_IDLE;
      nxt_st.wr_busy = 1'b0;
    end
    if (rd_go) begin
      nxt_st.data      = mem_ff[st_ff.addr];
      nxt_st.stall_cnt = 3'(nva_pkg::RD_STALL_CYC);
    end
    if (st_ff.stall_cnt != 3'h0 && !wr_go && !rd_go) begin
      nxt_st.stall_cnt = st_ff.stall_cnt - 3'h1;
    end
    nxt_st.stall = nxt_st.stall_cnt != 3'h0;
    // Read strobe never reads back as one: fetch is done at once
    nxt_st.rdata = reg_mux(io_addr, nxt_st);
  end

  function automatic logic [7:0] reg_mux(input logic [5:0] a,
                                         input nva_state_t s);
    logic [7:0] v;
    v = nva_pkg::REG_RST;
    if (a == nva_pkg::ADDR_REG_OFS) begin
      v = {1'b0, s.addr};
    end else if (a == nva_pkg::DATA_REG_OFS) begin
      v = s.data;
    end else if (a == nva_pkg::CTRL_REG_OFS) begin
      v = {5'h00, s.arm, s.wr_busy, 1'b0};
    end
    return v;
  endfunction : reg_mux

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Array: erase to all ones, then program
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < nva_pkg::ARRAY_DEPTH; i++) begin : g_cell
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_ff[i] <= nva_pkg::ERASED_BYTE;
        end else if (st_ff.addr == 7'(i)) begin
          if (st_ff.wst == ST_ERASE && st_ff.wcnt == '0) begin
            mem_ff[i] <= nva_pkg::ERASED_BYTE;
          end else if (st_ff.wst == ST_PROG && st_ff.wcnt >= WR_LAST
                       && !(wr_addr || wr_data)) begin
            mem_ff[i] <= st_ff.data;
          end
        end
      end
    end
  endgenerate

  assign io_rdata  = st_ff.rdata;
  assign cpu_stall = st_ff.stall;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence arm_set_s;
    wr_ctrl && io_wdata[nva_pkg::WR_ARM_BIT]
      && !io_wdata[nva_pkg::WR_STROBE_BIT];
  endsequence

  arm_timeout_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    arm_set_s ##1 (!wr_ctrl)[*4] |=> !st_ff.arm)
    else $error("arm bit did not time out");

  unarmed_ignore_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wr_ctrl && !st_ff.arm && !st_ff.wr_busy) |=> !st_ff.wr_busy)
    else $error("unarmed strobe started a write");

  armed_start_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_go |=> st_ff.wr_busy && st_ff.wst == ST_ERASE)
    else $error("armed strobe did not start a write");

  wr_stall_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    wr_go |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
    else $error("write stall not two cycles");

  rd_stall_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (rd_go && !wr_go) |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");

  rd_fetch_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    rd_go |=> st_ff.data == $past(mem_ff[st_ff.addr]))
    else $error("read did not load data register");

  abort_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (st_ff.wr_busy && (wr_addr || wr_data)) |=> !st_ff.wr_busy)
    else $error("write not aborted");

  ctrl_reserved_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    $past(io_addr) == nva_pkg::CTRL_REG_OFS |-> io_rdata[7:3] == 5'h00)
    else $error("reserved control bits not zero");

  reject_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (wr_ctrl && io_wdata[nva_pkg::WR_STROBE_BIT] && !st_ff.arm
     && !st_ff.wr_busy && !rd_go && st_ff.stall_cnt == 3'h0)
    |=> !cpu_stall && !st_ff.wr_busy)
    else $error("rejected strobe had an effect");

endmodule : nva_access_ctrl

/* File: nva_core_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Core issuing I/O instructions
// ----------------------------------------
module nva_core_model (
  // Clock
  input  wire logic       sys_clk,
  // I/O bus towards the block
  output logic      [5:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  initial begin
    io_addr  = 6'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    // Released bus shows the inverse, never a stale copy
    io_wdata <= ~d;
  endtask : io_write
  task automatic io_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask : io_read
  // Bounded poll, so a busy flag (bit 1) stuck high cannot hang the run
  task automatic wait_idle(output int polls);
    logic [7:0] c;
    polls = 0;
    do begin
      io_read(nva_pkg::CTRL_REG_OFS, c);
      polls++;
    end while (c[nva_pkg::WR_STROBE_BIT] !== 1'b0 && polls < 64);
  endtask : wait_idle
  // Arm and strobe back to back, so nothing slips in between
  task automatic write_byte(input logic [6:0] a, input logic [7:0] d);
    io_write(nva_pkg::ADDR_REG_OFS, {1'b0, a});
    io_write(nva_pkg::DATA_REG_OFS, d);
    io_write(nva_pkg::CTRL_REG_OFS, 8'h04);
    io_write(nva_pkg::CTRL_REG_OFS, 8'h02);
  endtask : write_byte
endmodule : nva_core_model

/* File: tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  n_fail++; $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  // ----------------------------------------
  // Design, core model and clock
  // ----------------------------------------
  localparam int WRC = 20;
  localparam logic [5:0] CTL = nva_pkg::CTRL_REG_OFS;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic [5:0] io_addr;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  int         n_fail;
  int         n_compared;
  always #5 sys_clk = ~sys_clk;
  nva_access_ctrl #(.WR_CYCLES(WRC)) i_nva_access_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall));
  nva_core_model core (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Counts stalled cycles over a window longer than any stall
  task automatic count_stall(output int n);
    n = 0;
    repeat (8) begin
      #1 if (cpu_stall === 1'b1) n++;
      @(posedge sys_clk);
    end
  endtask : count_stall
  task automatic rd_byte(input logic [6:0] a, output logic [7:0] d);
    int n;
    core.io_write(nva_pkg::ADDR_REG_OFS, {1'b0, a});
    core.io_write(CTL, 8'h01);
    count_stall(n);
    `CHK("rd_stall", 4, n)
    core.io_read(CTL, d);
    `CHK("rd_done", 8'h00, d)
    core.io_read(nva_pkg::DATA_REG_OFS, d);
  endtask : rd_byte
  initial begin
    int n;
    int el;
    logic [7:0] d;
    time t0;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    core.io_read(CTL, d);
    `CHK("ctrl_rst", 8'h00, d)
    core.io_write(CTL, 8'hf8);
    core.io_read(CTL, d);
    `CHK("ctrl_rsvd", 8'h00, d)
    core.io_write(nva_pkg::ADDR_REG_OFS, 8'hff);
    core.io_read(nva_pkg::ADDR_REG_OFS, d);
    `CHK("addr_msb", 8'h7f, d)
    rd_byte(7'h00, d);
    `CHK("erased", 8'hff, d)
    core.io_write(CTL, 8'h02);
    count_stall(n);
    `CHK("unarmed_stall", 0, n)
    core.io_read(CTL, d);
    `CHK("unarmed", 8'h00, d)
    core.io_write(CTL, 8'h04);
    core.io_read(CTL, d);
    `CHK("armed", 8'h04, d)
    repeat (4) @(posedge sys_clk);
    core.io_write(CTL, 8'h02);
    core.io_read(CTL, d);
    `CHK("arm_expired", 8'h00, d)
    core.write_byte(7'h7f, 8'ha5);
    t0 = $time;
    count_stall(n);
    `CHK("wr_stall", 2, n)
    core.io_read(CTL, d);
    `CHK("busy", 8'h02, d)
    core.wait_idle(n);
    el = int'(($time - t0) / 10);
    `CHK("poll_bound", 1'b1, n < 64)
    `CHK("wr_time", 1'b1, el >= WRC && el <= WRC + 6)
    rd_byte(7'h7f, d);
    `CHK("written", 8'ha5, d)
    // Abort a location that holds a5, so the early erase is visible
    core.write_byte(7'h7f, 8'h3c);
    count_stall(n);
    core.io_write(nva_pkg::DATA_REG_OFS, 8'h77);
    core.io_read(CTL, d);
    `CHK("aborted", 8'h00, d)
    rd_byte(7'h7f, d);
    `CHK("abort_erased", 8'hff, d)
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : tb_top
